/* verilog/asrc_pkg.sv */
package asrc_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int NGEN  = 4;
    localparam int NLAMP = 7;
    localparam int NACH  = 12;
    localparam int NPH   = 8;
    localparam int AW    = 10;
    localparam int SW    = 16;
    localparam int VW    = 12;
    // ****************************************
    // Angle and modes
    // ****************************************
    localparam logic [AW-1:0] ANG_PERIOD  = 10'h2D0;
    localparam logic [AW-1:0] ANG_ZERO    = 10'h000;
    localparam logic [3:0]    MODE_MASTER = 4'h8;
    localparam logic [2:0]    SYNC_IN     = 3'h1;
    localparam logic [2:0]    SYNC_GEN0   = 3'h2;
    localparam logic [2:0]    SYNC_BP0    = 3'h6;
    localparam logic [2:0]    BP_GEN0     = 3'h1;
    localparam logic [3:0]    ANA_LAST    = 4'hB;
    // ****************************************
    // Logic probe source positions
    // ****************************************
    localparam int LS_EXT_TRG = 0;
    localparam int LS_BP_TRG  = 2;
    localparam int LS_EXT_CLK = 4;
    localparam int LS_BP_CLK  = 6;
    localparam int LS_GEN_TRG = 8;
    localparam int LS_GEN_CLK = 12;
    localparam int LS_CH_CLK  = 16;
    localparam int LS_XTRG    = 32;
    localparam int LS_TP      = 40;
    typedef enum logic [1:0] {
        ASRC_IDLE = 2'b01,
        ASRC_RUN  = 2'b10
    } asrc_gen_st_t;
endpackage : asrc_pkg

/* verilog/asrc_core.sv */
`timescale 1ns/10ps
module asrc_core (
    input  wire logic                        core_clk,
    input  wire logic                        nrst,
    input  wire logic [6:0]                  panel_lamp_bit,
    input  wire logic [6:0]                  user_driven_lamp_mode,
    output logic      [6:0]                  panel_lamp_r,
    input  wire logic [1:0][3:0]             analog_probe_select,
    input  wire logic [11:0][11:0]           ana_wave,
    output logic      [1:0][11:0]            ana_probe_r,
    input  wire logic [1:0][5:0]             logic_probe_select,
    input  wire logic [11:0]                 ch_local_clk,
    output logic      [1:0]                  logic_probe_r,
    input  wire logic [3:0]                  panel_trigger_in,
    input  wire logic [3:0]                  panel_inhibit_in,
    output logic      [3:0]                  panel_trigger_level_r,
    output logic      [3:0]                  panel_inhibit_level_r,
    input  wire logic [3:0][3:0]             gen_mode,
    input  wire logic [3:0][15:0]            gen_speed,
    input  wire logic [3:0]                  gen_fwd,
    input  wire logic [3:0]                  gen_start_joint,
    input  wire logic [3:0]                  gen_start_flag,
    input  wire logic                        joint_start_group,
    input  wire logic [3:0][9:0]             first_trigger_offset,
    output logic      [3:0][9:0]             gen_angle_r,
    input  wire logic [3:0][1:0]             extra_trigger_ref,
    input  wire logic [3:0]                  knock_cfg,
    input  wire logic                        extra_trigger_phase_wr,
    input  wire logic [2:0]                  extra_trigger_phase_idx,
    input  wire logic [9:0]                  extra_trigger_phase,
    input  wire logic [1:0][2:0]             bp_sel,
    input  wire logic [1:0]                  bp_clk_in,
    input  wire logic [1:0]                  bp_dir_in,
    input  wire logic [1:0]                  bp_ref_in,
    output logic      [1:0]                  bp_clk_r,
    output logic      [1:0]                  bp_dir_r,
    output logic      [1:0]                  bp_ref_r,
    output logic      [1:0]                  bp_oe_r,
    input  wire logic [1:0][2:0]             sync_cfg,
    input  wire logic [1:0]                  sync_clk_in,
    input  wire logic [1:0]                  sync_dir_in,
    input  wire logic [1:0]                  sync_ref_in,
    output logic      [1:0]                  sync_clk_r,
    output logic      [1:0]                  sync_dir_r,
    output logic      [1:0]                  sync_ref_r,
    output logic      [1:0]                  sync_oe_r
);
    // ****************************************
    // Functions
    // ****************************************
    // Logic probe pick, zero above the table
    function automatic logic pick(input logic [5:0]  code,
                                  input logic [63:0] v);
        pick = v[code];
    endfunction : pick

    // Gen signal select by code base
    function automatic logic gsel(input logic [2:0] code,
                                  input logic [2:0] base,
                                  input logic [3:0] v);
        logic [2:0] d;
        d    = code - base;
        gsel = v[d[1:0]];
    endfunction : gsel

    // ****************************************
    // State
    // ****************************************
    asrc_pkg::asrc_gen_st_t [3:0] st_r;
    logic [3:0][15:0]            acc_r;
    logic [3:0]                  gclk_r;
    logic [3:0]                  gdir_r;
    logic [3:0]                  gref_r;
    logic [3:0]                  gtrg_r;
    logic [3:0]                  xtrg_r;
    logic [7:0][9:0]             phase_r;
    logic [7:0]                  sclk_q;
    logic [7:0]                  sref_q;
    logic                        joint_r;
    logic [3:0]                  mv;
    logic [3:0][9:0]             ang_nxt;
    logic [3:0][15:0]            acc_nxt;
    logic [3:0]                  gclk_nxt;
    logic [3:0]                  gdir_nxt;
    logic [3:0]                  gref_nxt;
    logic [3:0]                  gtrg_nxt;
    logic [3:0]                  xtrg_nxt;
    logic [3:0]                  run;
    logic [63:0]                 lvec;

    // ****************************************
    // Slave sources
    // ****************************************
    // Sockets feed only when set to input
    wire [1:0] sync_is_in = {sync_cfg[1] == asrc_pkg::SYNC_IN,
                             sync_cfg[0] == asrc_pkg::SYNC_IN};
    wire [7:0] src_clk = {sync_clk_in & sync_is_in, bp_clk_in, gclk_r};
    wire [7:0] src_dir = {sync_dir_in & sync_is_in, bp_dir_in, gdir_r};
    wire [7:0] src_ref = {sync_ref_in & sync_is_in, bp_ref_in, gref_r};
    wire [7:0] src_ce  = src_clk & ~sclk_q;
    wire [7:0] src_re  = src_ref & ~sref_q;

    // ****************************************
    // Angle generators
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < asrc_pkg::NGEN; g++) begin : gen_ang
            wire        master = gen_mode[g] == asrc_pkg::MODE_MASTER;
            wire [2:0]  sel    = gen_mode[g][2:0];
            wire [16:0] sum    = {1'b0, acc_r[g]} + {1'b0, gen_speed[g]};
            wire        req    = gen_start_joint[g] ? joint_r
                                                    : gen_start_flag[g];
            wire        step   = master ? sum[16] : src_ce[sel];
            wire        dir    = master ? gen_fwd[g] : src_dir[sel];
            wire        rsync  = ~master & src_re[sel];
            wire [9:0]  cur    = gen_angle_r[g];
            wire [9:0]  up     = (cur == asrc_pkg::ANG_PERIOD - 10'h001)
                                 ? asrc_pkg::ANG_ZERO : cur + 10'h001;
            wire [9:0]  dn     = (cur == asrc_pkg::ANG_ZERO)
                                 ? asrc_pkg::ANG_PERIOD - 10'h001
                                 : cur - 10'h001;
            // Running state follows the start request
            assign run[g]      = req;
            assign mv[g]       = (st_r[g] == asrc_pkg::ASRC_RUN)
                                 & (step | rsync);
            assign ang_nxt[g]  = (st_r[g] != asrc_pkg::ASRC_RUN)
                                 ? asrc_pkg::ANG_ZERO
                                 : rsync ? asrc_pkg::ANG_ZERO
                                 : step ? (dir ? up : dn) : cur;
            assign acc_nxt[g]  = (st_r[g] == asrc_pkg::ASRC_RUN)
                                 ? sum[15:0] : 16'h0000;
            assign gclk_nxt[g] = mv[g];
            assign gdir_nxt[g] = dir;
            assign gref_nxt[g] = mv[g] & (ang_nxt[g] == asrc_pkg::ANG_ZERO);
            assign gtrg_nxt[g] = mv[g]
                                 & (ang_nxt[g] == first_trigger_offset[g]);
        end
    endgenerate

    // ****************************************
    // Extra triggers
    // ****************************************
    generate
        for (g = 0; g < asrc_pkg::NGEN; g++) begin : gen_xtrg
            wire [1:0] r = extra_trigger_ref[g];
            wire       hit = (ang_nxt[r] == phase_r[g])
                             | (ang_nxt[r] == phase_r[g + 4]);
            assign xtrg_nxt[g] = ~knock_cfg[g] & mv[r] & hit;
        end
    endgenerate

    // ****************************************
    // Logic probe source table
    // ****************************************
    always_comb begin
        lvec = 64'h0000_0000_0000_0000;
        lvec[asrc_pkg::LS_EXT_TRG +: 2]  = src_ref[7:6];
        lvec[asrc_pkg::LS_BP_TRG +: 2]   = bp_ref_in;
        lvec[asrc_pkg::LS_EXT_CLK +: 2]  = src_clk[7:6];
        lvec[asrc_pkg::LS_BP_CLK +: 2]   = bp_clk_in;
        lvec[asrc_pkg::LS_GEN_TRG +: 4]  = gtrg_r;
        lvec[asrc_pkg::LS_GEN_CLK +: 4]  = gclk_r;
        lvec[asrc_pkg::LS_CH_CLK +: 12] = ch_local_clk;
        lvec[asrc_pkg::LS_XTRG +: 4]     = xtrg_r;
        lvec[asrc_pkg::LS_TP +: 6]       = {|gclk_r, joint_r, gdir_r};
    end

    // ****************************************
    // Generator registers
    // ****************************************
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < asrc_pkg::NGEN; i++) begin
                st_r[i]        <= asrc_pkg::ASRC_IDLE;
                acc_r[i]       <= 16'h0000;
                gen_angle_r[i] <= 10'h000;
            end
            gclk_r  <= 4'h0;
            gdir_r  <= 4'h0;
            gref_r  <= 4'h0;
            gtrg_r  <= 4'h0;
            xtrg_r  <= 4'h0;
            sclk_q  <= 8'h00;
            sref_q  <= 8'h00;
            joint_r <= 1'b0;
        end else begin
            for (int i = 0; i < asrc_pkg::NGEN; i++) begin
                case (st_r[i])
                    asrc_pkg::ASRC_IDLE: if (run[i]) begin
                        st_r[i] <= asrc_pkg::ASRC_RUN;
                    end
                    asrc_pkg::ASRC_RUN: if (!run[i]) begin
                        st_r[i] <= asrc_pkg::ASRC_IDLE;
                    end
                    default: st_r[i] <= asrc_pkg::ASRC_IDLE;
                endcase
                acc_r[i]       <= acc_nxt[i];
                gen_angle_r[i] <= ang_nxt[i];
            end
            gclk_r  <= gclk_nxt;
            gdir_r  <= gdir_nxt;
            gref_r  <= gref_nxt;
            gtrg_r  <= gtrg_nxt;
            xtrg_r  <= xtrg_nxt;
            sclk_q  <= src_clk;
            sref_q  <= src_ref;
            joint_r <= joint_start_group;
        end
    end

    // Extra trigger phase store
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            phase_r <= '0;
        end else if (extra_trigger_phase_wr) begin
            phase_r[extra_trigger_phase_idx] <= extra_trigger_phase;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            panel_lamp_r          <= 7'h00;
            ana_probe_r           <= '0;
            logic_probe_r         <= 2'h0;
            panel_trigger_level_r <= 4'h0;
            panel_inhibit_level_r <= 4'h0;
            bp_clk_r              <= 2'h0;
            bp_dir_r              <= 2'h0;
            bp_ref_r              <= 2'h0;
            bp_oe_r               <= 2'h0;
            sync_clk_r            <= 2'h0;
            sync_dir_r            <= 2'h0;
            sync_ref_r            <= 2'h0;
            sync_oe_r             <= 2'h0;
        end else begin
            panel_lamp_r <= panel_lamp_bit & user_driven_lamp_mode;
            panel_trigger_level_r <= panel_trigger_in;
            panel_inhibit_level_r <= panel_inhibit_in;
            for (int p = 0; p < 2; p++) begin
                ana_probe_r[p] <=
                    (analog_probe_select[p] <= asrc_pkg::ANA_LAST)
                    ? ana_wave[analog_probe_select[p]] : 12'h000;
                logic_probe_r[p] <= pick(logic_probe_select[p], lvec);
                // Backplane drive from a local generator
                bp_oe_r[p]  <= bp_sel[p] >= asrc_pkg::BP_GEN0
                               && bp_sel[p] < asrc_pkg::BP_GEN0 + 3'h4;
                bp_clk_r[p] <= gsel(bp_sel[p], asrc_pkg::BP_GEN0, gclk_r);
                bp_dir_r[p] <= gsel(bp_sel[p], asrc_pkg::BP_GEN0, gdir_r);
                bp_ref_r[p] <= gsel(bp_sel[p], asrc_pkg::BP_GEN0, gref_r);
                // Socket drive from generator or backplane
                sync_oe_r[p] <= sync_cfg[p] >= asrc_pkg::SYNC_GEN0;
                if (sync_cfg[p] >= asrc_pkg::SYNC_BP0) begin
                    sync_clk_r[p] <= bp_clk_in[sync_cfg[p][0]];
                    sync_dir_r[p] <= bp_dir_in[sync_cfg[p][0]];
                    sync_ref_r[p] <= bp_ref_in[sync_cfg[p][0]];
                end else begin
                    sync_clk_r[p] <= gsel(sync_cfg[p], asrc_pkg::SYNC_GEN0,
                                          gclk_r);
                    sync_dir_r[p] <= gsel(sync_cfg[p], asrc_pkg::SYNC_GEN0,
                                          gdir_r);
                    sync_ref_r[p] <= gsel(sync_cfg[p], asrc_pkg::SYNC_GEN0,
                                          gref_r);
                end
            end
        end
    end
endmodule : asrc_core

/* tb/asrc_chk_asserts.sv */
`timescale 1ns/10ps
// ****************************
// Port checker
// ****************************
module asrc_chk (
    input wire logic                core_clk,
    input wire logic                nrst,
    input wire logic [6:0]          panel_lamp_bit,
    input wire logic [6:0]          user_driven_lamp_mode,
    input wire logic [6:0]          panel_lamp_r,
    input wire logic [1:0][3:0]     analog_probe_select,
    input wire logic [11:0][11:0]   ana_wave,
    input wire logic [1:0][11:0]    ana_probe_r,
    input wire logic [1:0][5:0]     logic_probe_select,
    input wire logic [11:0]         ch_local_clk,
    input wire logic [1:0]          logic_probe_r,
    input wire logic [1:0]          bp_clk_in,
    input wire logic [1:0]          bp_ref_in,
    input wire logic [1:0][2:0]     bp_sel,
    input wire logic [1:0]          bp_oe_r,
    input wire logic [1:0][2:0]     sync_cfg,
    input wire logic [1:0]          sync_oe_r,
    input wire logic [1:0]          bp_dir_in,
    input wire logic [1:0]          bp_clk_r,
    input wire logic [3:0][9:0]     gen_angle_r,
    input wire logic [1:0]          sync_clk_r,
    input wire logic [1:0]          sync_dir_r,
    input wire logic [1:0]          sync_ref_r
);
    // One clock, reset off while low
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Registered routing, one cycle behind its cause
    property p_lamp; 1 |=> panel_lamp_r ==
        $past(panel_lamp_bit & user_driven_lamp_mode); endproperty
    a_lamp: assert property (p_lamp) else $error("lamp wrong");
    property p_ana; 1 |=> ana_probe_r[0] == ($past(analog_probe_select[0])
        <= 4'hB ? $past(ana_wave[analog_probe_select[0]]) : 12'h000);
    endproperty
    a_ana: assert property (p_ana) else $error("analog probe wrong");
    property p_bpt; logic_probe_select[0] inside {6'h02, 6'h03} |=>
        logic_probe_r[0] == $past(bp_ref_in[logic_probe_select[0][0]]);
    endproperty
    a_bpt: assert property (p_bpt) else $error("bp trigger wrong");
    property p_bpc; logic_probe_select[0] inside {6'h06, 6'h07} |=>
        logic_probe_r[0] == $past(bp_clk_in[logic_probe_select[0][0]]);
    endproperty
    a_bpc: assert property (p_bpc) else $error("bp clock wrong");
    property p_chc; logic_probe_select[0] inside {[6'h10:6'h1B]} |=>
        logic_probe_r[0] == $past(ch_local_clk[logic_probe_select[0]-6'h10]);
    endproperty
    a_chc: assert property (p_chc) else $error("chan clock wrong");
    property p_off; logic_probe_select[1] inside {[6'h1C:6'h1F],
        [6'h24:6'h27], [6'h2E:6'h3F]} |=> !logic_probe_r[1]; endproperty
    a_off: assert property (p_off) else $error("idle code not low");
    property p_bp; 1 |=> bp_oe_r[0] ==
        ($past(bp_sel[0]) inside {[3'h1:3'h4]}); endproperty
    a_bp: assert property (p_bp) else $error("bp enable wrong");
    property p_sy; 1 |=> sync_oe_r[1] ==
        ($past(sync_cfg[1]) >= 3'h2); endproperty
    a_sy: assert property (p_sy) else $error("sync enable wrong");
    // Backplane clock pulses once per step of generator 0
    property p_bpk; bp_sel[0] == 3'h1 |=> bp_clk_r[0] ==
        ($past(gen_angle_r[0]) != $past(gen_angle_r[0], 2))
        || $past(gen_angle_r[0]) == 10'h000; endproperty
    a_bpk: assert property (p_bpk) else $error("bp gen clock wrong");
    // Socket repeats the chosen backplane signal
    property p_syb; sync_cfg[0] inside {3'h6, 3'h7} |=>
        {sync_clk_r[0], sync_dir_r[0], sync_ref_r[0]} ==
        $past({bp_clk_in[sync_cfg[0][0]], bp_dir_in[sync_cfg[0][0]],
        bp_ref_in[sync_cfg[0][0]]}); endproperty
    a_syb: assert property (p_syb) else $error("sync from bp wrong");
    // Main scenarios reached
    c_chc: cover property (logic_probe_select[0] == 6'h10);
    c_lamp: cover property (panel_lamp_r != 7'h00);
    c_bp: cover property (bp_oe_r[0]);
endmodule : asrc_chk

/* tb/asrc_far.sv */
`timescale 1ns/10ps
// ****************************
// Far-side angle source pair
// ****************************
module asrc_far #(
    parameter int PER = 4
) (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic [1:0] run,
    output logic      [1:0] clk_o,
    output logic      [1:0] dir_o,
    output logic      [1:0] ref_o
);
    logic [7:0] cnt_r;
    logic [2:0] pos_r;
    // Clock divider and position within a turn of eight pulses
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 8'h00;
            pos_r <= 3'h0;
        end else begin
            cnt_r <= (cnt_r == 8'(PER - 1)) ? 8'h00 : cnt_r + 8'h01;
            pos_r <= (cnt_r == 8'h00) ? pos_r + 3'h1 : pos_r;
        end
    end
    // One-cycle pulses with low gaps, still when not running
    assign clk_o = run & {2{cnt_r == 8'h00}};
    assign ref_o = run & {2{cnt_r == 8'h00 && pos_r == 3'h0}};
    assign dir_o = run;
endmodule : asrc_far

/* tb/testbench.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module testbench;
    // ****************************
    // Signals
    // ****************************
    logic                core_clk, nrst = 1'b0, joint_start_group = 1'b0;
    logic                extra_trigger_phase_wr = 1'b0;
    logic [6:0]          panel_lamp_bit = '0, user_driven_lamp_mode = '0;
    logic [1:0][3:0]     analog_probe_select = '0;
    logic [11:0][11:0]   ana_wave = '0;
    logic [1:0][5:0]     logic_probe_select = '0;
    logic [11:0]         ch_local_clk = '0;
    logic [3:0]          panel_trigger_in = '0, panel_inhibit_in = '0;
    logic [3:0]          gen_fwd = '0, gen_start_joint = '0;
    logic [3:0]          gen_start_flag = '0, knock_cfg = '0;
    logic [3:0][3:0]     gen_mode = '0;
    logic [3:0][15:0]    gen_speed = '0;
    logic [3:0][9:0]     first_trigger_offset = '0;
    logic [3:0][1:0]     extra_trigger_ref = '0;
    logic [2:0]          extra_trigger_phase_idx = '0;
    logic [9:0]          extra_trigger_phase = '0;
    logic [1:0][2:0]     bp_sel = '0, sync_cfg = '0;
    logic [6:0]          panel_lamp_r;
    logic [1:0][11:0]    ana_probe_r;
    logic [3:0]          panel_trigger_level_r, panel_inhibit_level_r;
    logic [3:0][9:0]     gen_angle_r;
    logic [1:0]          logic_probe_r, bp_clk_in, bp_dir_in, bp_ref_in;
    logic [1:0]          bp_clk_r, bp_dir_r, bp_ref_r, bp_oe_r, sync_oe_r;
    logic [1:0]          sync_clk_in, sync_dir_in, sync_ref_in;
    logic [1:0]          sync_clk_r, sync_dir_r, sync_ref_r;
    logic [1:0]          pb_clk, pb_dir, pb_ref, ps_clk, ps_dir, ps_ref;
    int                  n_fail = 0, tests_run = 0, nc = 0;
    logic [15:0]         r = 16'hF738;
    typedef struct {int s; logic [39:0] e; int due;} asrc_note_t;
    asrc_note_t          q[$];
    asrc_note_t          n;
    // Shared lines: design drives while enabled, else the far side
    assign bp_clk_in = (bp_oe_r & bp_clk_r) | (~bp_oe_r & pb_clk);
    assign bp_dir_in = (bp_oe_r & bp_dir_r) | (~bp_oe_r & pb_dir);
    assign bp_ref_in = (bp_oe_r & bp_ref_r) | (~bp_oe_r & pb_ref);
    assign sync_clk_in = (sync_oe_r & sync_clk_r) | ps_clk;
    assign sync_dir_in = (sync_oe_r & sync_dir_r) | ps_dir;
    assign sync_ref_in = (sync_oe_r & sync_ref_r) | ps_ref;
    asrc_core DUT (.*);
    asrc_far #(.PER(6)) u_bp (.core_clk(core_clk), .nrst(nrst), .run(2'h3),
        .clk_o(pb_clk), .dir_o(pb_dir), .ref_o(pb_ref));
    asrc_far #(.PER(3)) u_sy (.core_clk(core_clk), .nrst(nrst),
        .run({sync_cfg[1] == 3'h1, sync_cfg[0] == 3'h1}),
        .clk_o(ps_clk), .dir_o(ps_dir), .ref_o(ps_ref));
    // ****************************
    // Helpers
    // ****************************
    function automatic logic [15:0] lfsr(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    function automatic logic [39:0] obs(int s);
        case (s)
            0: return 40'(panel_lamp_r);
            1: return 40'(ana_probe_r);
            2: return 40'({panel_trigger_level_r, panel_inhibit_level_r});
            3: return 40'(logic_probe_r[0]);
            4: return 40'(logic_probe_r[1]);
            5: return 40'({bp_oe_r, sync_oe_r});
            6: return 40'({10'(gen_angle_r[1] - gen_angle_r[0]), 11'((11'(
                gen_angle_r[2]) + 11'(gen_angle_r[0])) % 11'h2D0)});
            7: return 40'(gen_angle_r[0] == 10'h000);
            9: return 40'(gen_angle_r[3] != {7'h00, 3'(u_sy.pos_r - 3'h1)});
            10: return 40'({bp_ref_r, bp_dir_r, logic_probe_r});
            default: return 40'(gen_angle_r);
        endcase
    endfunction : obs
    task automatic note(int s, logic [39:0] e);
        q.push_back('{s, e, nc + 2});
    endtask : note
    task automatic report_and_stop();
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    // Clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        n_fail++;
        report_and_stop();
    end
    // Result watcher: oldest note compared once its cycle has come
    always @(negedge core_clk) begin
        nc++;
        while (q.size() > 0 && q[0].due <= nc) begin
            n = q.pop_front();
            `CHK(obs(n.s), n.e)
        end
    end
    // ****************************
    // Scenarios
    // ****************************
    initial begin
        for (int i = 0; i < 12; i++) ana_wave[i] = 12'(i * 12'h131 + 12'h0A5);
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(posedge core_clk);
            r = lfsr(r);
            panel_lamp_bit <= r[6:0];
            user_driven_lamp_mode <= r[13:7];
            panel_trigger_in <= r[3:0];
            panel_inhibit_in <= r[11:8];
            analog_probe_select <= {r[15:12], r[3:0]};
            note(0, 40'(r[6:0] & r[13:7]));
            note(2, 40'({r[3:0], r[11:8]}));
            note(1, 40'({r[15:12] <= 4'hB ? ana_wave[r[15:12]] : 12'h000,
                r[3:0] <= 4'hB ? ana_wave[r[3:0]] : 12'h000}));
        end
        for (int i = 0; i < 64; i++) begin
            @(posedge core_clk);
            r = lfsr(r);
            ch_local_clk <= r[11:0];
            logic_probe_select <= {6'(63 - i), 6'(i)};
            if (i >= 16 && i <= 27) note(3, 40'(r[i - 16]));
            if ((63 - i) inside {[28:31], [36:39], [46:63]}) note(4, 40'h0);
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            bp_sel <= {3'(7 - i), 3'(i)};
            sync_cfg <= {3'(7 - i), 3'(i)};
            note(5, 40'({(7 - i) inside {[1:4]}, i inside {[1:4]},
                (7 - i) >= 2, i >= 2}));
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            extra_trigger_phase_wr <= 1'b1;
            extra_trigger_phase_idx <= 3'(i);
            extra_trigger_phase <= 10'(i * 5);
        end
        @(posedge core_clk);
        extra_trigger_phase_wr <= 1'b0;
        knock_cfg <= 4'h2;
        extra_trigger_ref <= {2'h3, 2'h2, 2'h1, 2'h0};
        sync_cfg <= {3'h0, 3'h1};
        bp_sel <= {3'h2, 3'h1};
        @(posedge core_clk);
        gen_mode <= {4'h6, 4'h8, 4'h8, 4'h8};
        logic_probe_select <= {6'h21, 6'h20};
        gen_speed <= {4{16'h4000}};
        gen_fwd <= 4'h3;
        first_trigger_offset <= {4{10'h05A}};
        gen_start_joint <= 4'h7;
        gen_start_flag <= 4'h8;
        joint_start_group <= 1'b1;
        for (int i = 0; i < 200; i++) begin
            @(posedge core_clk);
            note(6, 40'h0);
            note(10, 40'({4'h3, 1'b0, i == 81}));
            if (i >= 100 && i < 190) note(9, 40'h0);
        end
        note(7, 40'h0);
        joint_start_group <= 1'b0;
        gen_start_flag <= 4'h0;
        repeat (4) @(posedge core_clk);
        note(8, 40'h0);
        repeat (3) @(posedge core_clk);
        report_and_stop();
    end
endmodule : testbench
bind asrc_core asrc_chk u_chk (.*);
